// [core/ldi_regs.svh]
/*
  Constants of the LCD driver data interface: register offsets, field
  positions, reset values and shift counts.
  Assumes inclusion by bare name from the package and the core.
*/
`ifndef LDI_REGS_SVH
`define LDI_REGS_SVH

`define LDI_NUM_OUT        80
`define LDI_SEG_STAGES     20
`define LDI_SEG_WIDTH      4
`define LDI_HALF_OUT       40
`define LDI_CNT_W          7
`define LDI_ADDR_W         8
`define LDI_SYNC_W         13

`define LDI_OFF_CTRL       8'h00
`define LDI_OFF_STATUS     8'h04
`define LDI_OFF_DATA0      8'h08
`define LDI_OFF_DATA1      8'h0C
`define LDI_OFF_DATA2      8'h10

`define LDI_CTRL_BLANK_POS 0
`define LDI_CTRL_RESET     1'h0

`define LDI_ST_ROLE_POS    0
`define LDI_ST_MODE_POS    1
`define LDI_ST_DIR_POS     2
`define LDI_ST_EN_POS      3
`define LDI_ST_FULL_POS    4
`define LDI_ST_CNT_POS     8

`define LDI_RESP_OKAY      2'h0
`define LDI_RESP_SLVERR    2'h2

`endif

// [core/ldi_pkg.sv]
/*
  Types of the LCD driver data interface: drive level codes, register
  select codes and the complete state record of the core.
  Assumes ldi_regs.svh sits on the include path.
*/
`include "ldi_regs.svh"

package ldi_pkg;

  typedef enum logic [1:0] {
    LVL_TOP,
    LVL_UPPER_MID,
    LVL_LOWER_MID,
    LVL_BOTTOM
  } ldi_level_t;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_STATUS,
    SEL_DATA0,
    SEL_DATA1,
    SEL_DATA2,
    SEL_NONE
  } ldi_sel_t;

  typedef struct packed {
    logic [`LDI_NUM_OUT-1:0]        shift_reg;
    logic [`LDI_NUM_OUT-1:0]        latch_reg;
    logic [`LDI_CNT_W-1:0]          count_reg;
    logic                           full_reg;
    logic                           shclk_reg;
    logic                           ltclk_reg;
    logic [`LDI_NUM_OUT-1:0][1:0]   drive_reg;
    logic                           blank_reg;
    logic                           aw_got_reg;
    logic                           w_got_reg;
    logic [`LDI_ADDR_W-1:0]         awaddr_reg;
    logic [31:0]                    wdata_reg;
    logic [3:0]                     wstrb_reg;
    logic                           bvalid_reg;
    logic [1:0]                     bresp_reg;
    logic                           rvalid_reg;
    logic [31:0]                    rdata_reg;
    logic [1:0]                     rresp_reg;
  } ldi_state_t;

endpackage : ldi_pkg

// [core/ldi_sync.sv]
/*
  Two-stage synchroniser for a group of asynchronous pin levels.
  Assumes each bit is an independent level; multi-bit words are not coherent.
*/
`timescale 1ns/1ns
`include "ldi_regs.svh"

module ldi_sync #(
  parameter int W = `LDI_SYNC_W
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // Upper half is the first stage, read only by the lower half
  logic [2*W-1:0] stages_reg;
  logic [2*W-1:0] stages_next;

  always_comb begin
    stages_next = {i_async, stages_reg[2*W-1:W]};
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      stages_reg <= '0;
    end else begin
      stages_reg <= stages_next;
    end
  end

  assign o_sync = stages_reg[W-1:0];

endmodule : ldi_sync

// [core/ldi_core.sv]
/*
  LCD driver data interface core: segment/common role, parallel, serial,
  single and dual shift paths, cascade enables, latch and level selection
  for 80 outputs, plus an AXI4-Lite register slave.
  Assumes all pins are asynchronous to i_clk_sys and that the shift and
  latch clocks run slowly enough for two-stage sampling to see every edge.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ldi_regs.svh"

module ldi_core (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_sys_rst,
  // Display pins
  input  wire logic                        i_data_pin_one_serial_in,
  input  wire logic                        i_data_pin_two_left_end,
  output logic                             o_data_pin_two_left_end,
  output logic                             o_data_pin_two_left_end_oe,
  input  wire logic                        i_data_pin_three_middle,
  input  wire logic                        i_data_pin_four_right_end,
  output logic                             o_data_pin_four_right_end,
  output logic                             o_data_pin_four_right_end_oe,
  input  wire logic                        i_shift_direction_sel,
  input  wire logic                        i_chain_enable_left_n,
  output logic                             o_chain_enable_left_n,
  output logic                             o_chain_enable_left_oe,
  input  wire logic                        i_chain_enable_right_n,
  output logic                             o_chain_enable_right_n,
  output logic                             o_chain_enable_right_oe,
  input  wire logic                        i_application_mode_sel,
  input  wire logic                        i_driver_role_sel,
  input  wire logic                        i_frame_invert,
  input  wire logic                        i_display_off_n,
  input  wire logic                        i_latch_clock,
  input  wire logic                        i_shift_clock,
  output logic [2*`LDI_NUM_OUT-1:0]        o_drive_outputs,
  // AXI4-Lite slave
  input  wire logic [`LDI_ADDR_W-1:0]      i_s_axi_awaddr,
  input  wire logic                        i_s_axi_awvalid,
  output logic                             o_s_axi_awready,
  input  wire logic [31:0]                 i_s_axi_wdata,
  input  wire logic [3:0]                  i_s_axi_wstrb,
  input  wire logic                        i_s_axi_wvalid,
  output logic                             o_s_axi_wready,
  output logic [1:0]                       o_s_axi_bresp,
  output logic                             o_s_axi_bvalid,
  input  wire logic                        i_s_axi_bready,
  input  wire logic [`LDI_ADDR_W-1:0]      i_s_axi_araddr,
  input  wire logic                        i_s_axi_arvalid,
  output logic                             o_s_axi_arready,
  output logic [31:0]                      o_s_axi_rdata,
  output logic [1:0]                       o_s_axi_rresp,
  output logic                             o_s_axi_rvalid,
  input  wire logic                        i_s_axi_rready
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic ldi_pkg::ldi_sel_t reg_decode(input logic [`LDI_ADDR_W-1:0] addr);
    case (addr)
      `LDI_OFF_CTRL:   reg_decode = ldi_pkg::SEL_CTRL;
      `LDI_OFF_STATUS: reg_decode = ldi_pkg::SEL_STATUS;
      `LDI_OFF_DATA0:  reg_decode = ldi_pkg::SEL_DATA0;
      `LDI_OFF_DATA1:  reg_decode = ldi_pkg::SEL_DATA1;
      `LDI_OFF_DATA2:  reg_decode = ldi_pkg::SEL_DATA2;
      default:         reg_decode = ldi_pkg::SEL_NONE;
    endcase
  endfunction : reg_decode

  function automatic ldi_pkg::ldi_level_t level_sel(
    input logic common,
    input logic frame,
    input logic data,
    input logic on
  );
    if (!on) begin
      level_sel = ldi_pkg::LVL_TOP;
    end else begin
      case ({frame, data})
        2'h0:    level_sel = ldi_pkg::LVL_UPPER_MID;
        2'h1:    level_sel = common ? ldi_pkg::LVL_BOTTOM : ldi_pkg::LVL_TOP;
        2'h2:    level_sel = ldi_pkg::LVL_LOWER_MID;
        default: level_sel = common ? ldi_pkg::LVL_TOP : ldi_pkg::LVL_BOTTOM;
      endcase
    end
  endfunction : level_sel

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [`LDI_SYNC_W-1:0] pins_sync;
  logic                   d1_s;
  logic                   dl_s;
  logic                   dm_s;
  logic                   dr_s;
  logic                   dir_s;
  logic                   enl_s;
  logic                   enr_s;
  logic                   mode_s;
  logic                   role_s;
  logic                   frame_s;
  logic                   on_s;
  logic                   ltclk_s;
  logic                   shclk_s;

  ldi_sync #(
    .W (`LDI_SYNC_W)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_data_pin_one_serial_in, i_data_pin_two_left_end, i_data_pin_three_middle,
                 i_data_pin_four_right_end, i_shift_direction_sel, i_chain_enable_left_n,
                 i_chain_enable_right_n, i_application_mode_sel, i_driver_role_sel,
                 i_frame_invert, i_display_off_n, i_latch_clock, i_shift_clock}),
    .o_sync    (pins_sync)
  );

  // Role and mode are used as sampled every cycle; mid-frame changes are not guarded
  assign {d1_s, dl_s, dm_s, dr_s, dir_s, enl_s, enr_s, mode_s, role_s,
          frame_s, on_s, ltclk_s, shclk_s} = pins_sync;

  //////////////////////////////////////////////////////////////////////////////
  // State

  ldi_pkg::ldi_state_t st;
  ldi_pkg::ldi_state_t nx;

  localparam ldi_pkg::ldi_state_t ST_RESET = '{
    shift_reg:  '0,
    latch_reg:  '0,
    count_reg:  '0,
    full_reg:   1'b0,
    shclk_reg:  1'b0,
    ltclk_reg:  1'b0,
    drive_reg:  '0,
    blank_reg:  `LDI_CTRL_RESET,
    aw_got_reg: 1'b0,
    w_got_reg:  1'b0,
    awaddr_reg: '0,
    wdata_reg:  '0,
    wstrb_reg:  '0,
    bvalid_reg: 1'b0,
    bresp_reg:  `LDI_RESP_OKAY,
    rvalid_reg: 1'b0,
    rdata_reg:  '0,
    rresp_reg:  `LDI_RESP_OKAY
  };

  //////////////////////////////////////////////////////////////////////////////
  // Level selection per output

  logic                              common;
  logic [`LDI_NUM_OUT-1:0]           shown;
  logic [`LDI_NUM_OUT-1:0][1:0]      levels;

  assign common = role_s;
  // Common outputs follow the scan register, segment outputs the latch
  assign shown  = common ? st.shift_reg : st.latch_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `LDI_NUM_OUT; gi++) begin : g_level
      assign levels[gi] = level_sel(common, frame_s, shown[gi], on_s & ~st.blank_reg);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  logic                    sh_fall;
  logic                    lt_fall;
  logic                    en_in_n;
  logic [`LDI_CNT_W-1:0]   limit;
  logic                    aw_have;
  logic                    w_have;
  logic                    ar_take;
  logic [`LDI_NUM_OUT-1:0] sr;
  ldi_pkg::ldi_sel_t       wsel;
  logic [31:0]             status;

  assign sh_fall = st.shclk_reg & ~shclk_s;
  assign lt_fall = st.ltclk_reg & ~ltclk_s;
  assign en_in_n = dir_s ? enr_s : enl_s;
  assign limit   = mode_s ? `LDI_CNT_W'(`LDI_NUM_OUT) : `LDI_CNT_W'(`LDI_SEG_STAGES);
  assign aw_have = st.aw_got_reg | (i_s_axi_awvalid & o_s_axi_awready);
  assign w_have  = st.w_got_reg | (i_s_axi_wvalid & o_s_axi_wready);
  assign ar_take = i_s_axi_arvalid & o_s_axi_arready;
  assign status  = {16'h0, 1'b0, st.count_reg, 3'h0, st.full_reg, ~en_in_n, dir_s, mode_s, role_s};

  always_comb begin
    nx           = st;
    sr           = st.shift_reg;
    wsel         = reg_decode(aw_have && st.aw_got_reg ? st.awaddr_reg : i_s_axi_awaddr);
    nx.shclk_reg = shclk_s;
    nx.ltclk_reg = ltclk_s;
    nx.drive_reg = levels;

    if (!common) begin
      if (ltclk_s) begin
        // Latch-clock high restarts the power-down block for the next line
        nx.count_reg = '0;
        nx.full_reg  = 1'b0;
      end else if (sh_fall && !en_in_n && !st.full_reg) begin
        if (!mode_s) begin
          sr = dir_s ? {d1_s, dl_s, dm_s, dr_s, st.shift_reg[`LDI_NUM_OUT-1:`LDI_SEG_WIDTH]}
                     : {st.shift_reg[`LDI_NUM_OUT-`LDI_SEG_WIDTH-1:0], dr_s, dm_s, dl_s, d1_s};
        end else begin
          sr = dir_s ? {d1_s, st.shift_reg[`LDI_NUM_OUT-1:1]}
                     : {st.shift_reg[`LDI_NUM_OUT-2:0], d1_s};
        end
        nx.count_reg = st.count_reg + `LDI_CNT_W'(1);
        nx.full_reg  = (st.count_reg + `LDI_CNT_W'(1)) == limit;
      end
      if (lt_fall) begin
        nx.latch_reg = st.shift_reg;
      end
    end else begin
      nx.count_reg = '0;
      nx.full_reg  = 1'b0;
      if (lt_fall) begin
        if (!mode_s) begin
          sr = dir_s ? {dr_s, st.shift_reg[`LDI_NUM_OUT-1:1]}
                     : {st.shift_reg[`LDI_NUM_OUT-2:0], dl_s};
        end else if (!dir_s) begin
          sr = {st.shift_reg[`LDI_NUM_OUT-2:`LDI_HALF_OUT], dm_s,
                st.shift_reg[`LDI_HALF_OUT-2:0], dl_s};
        end else begin
          sr = {dr_s, st.shift_reg[`LDI_NUM_OUT-1:`LDI_HALF_OUT+1],
                dm_s, st.shift_reg[`LDI_HALF_OUT-1:1]};
        end
      end
    end
    nx.shift_reg = sr;

    // Write channel: address and data may arrive in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      nx.aw_got_reg = 1'b1;
      nx.awaddr_reg = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      nx.w_got_reg = 1'b1;
      nx.wdata_reg = i_s_axi_wdata;
      nx.wstrb_reg = i_s_axi_wstrb;
    end
    if (st.bvalid_reg && i_s_axi_bready) begin
      nx.bvalid_reg = 1'b0;
    end
    if (aw_have && w_have && !st.bvalid_reg) begin
      nx.aw_got_reg = 1'b0;
      nx.w_got_reg  = 1'b0;
      nx.bvalid_reg = 1'b1;
      nx.bresp_reg  = `LDI_RESP_OKAY;
      case (wsel)
        ldi_pkg::SEL_CTRL: begin
          if (st.w_got_reg ? st.wstrb_reg[0] : i_s_axi_wstrb[0]) begin
            nx.blank_reg = st.w_got_reg ? st.wdata_reg[`LDI_CTRL_BLANK_POS]
                                        : i_s_axi_wdata[`LDI_CTRL_BLANK_POS];
          end
        end
        ldi_pkg::SEL_STATUS, ldi_pkg::SEL_DATA0, ldi_pkg::SEL_DATA1, ldi_pkg::SEL_DATA2: begin
          nx.bresp_reg = `LDI_RESP_OKAY;
        end
        default: begin
          nx.bresp_reg = `LDI_RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (st.rvalid_reg && i_s_axi_rready) begin
      nx.rvalid_reg = 1'b0;
    end
    if (ar_take) begin
      nx.rvalid_reg = 1'b1;
      nx.rresp_reg  = `LDI_RESP_OKAY;
      case (reg_decode(i_s_axi_araddr))
        ldi_pkg::SEL_CTRL:   nx.rdata_reg = {31'h0, st.blank_reg};
        ldi_pkg::SEL_STATUS: nx.rdata_reg = status;
        ldi_pkg::SEL_DATA0:  nx.rdata_reg = shown[31:0];
        ldi_pkg::SEL_DATA1:  nx.rdata_reg = shown[63:32];
        ldi_pkg::SEL_DATA2:  nx.rdata_reg = {16'h0, shown[`LDI_NUM_OUT-1:64]};
        default: begin
          nx.rdata_reg = 32'h0;
          nx.rresp_reg = `LDI_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= ST_RESET;
    end else begin
      st <= nx;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Enables only drive in segment mode; the far pin is the output
  assign o_chain_enable_left_oe       = ~common & dir_s;
  assign o_chain_enable_right_oe      = ~common & ~dir_s;
  assign o_chain_enable_left_n        = ~st.full_reg;
  assign o_chain_enable_right_n       = ~st.full_reg;
  // Segment mode never drives data pins, so unused ones may float
  assign o_data_pin_four_right_end_oe = common & ~dir_s;
  assign o_data_pin_two_left_end_oe   = common & dir_s;
  assign o_data_pin_four_right_end    = st.shift_reg[`LDI_NUM_OUT-1];
  assign o_data_pin_two_left_end      = st.shift_reg[0];
  assign o_drive_outputs              = st.drive_reg;

  assign o_s_axi_awready = ~st.aw_got_reg & ~st.bvalid_reg;
  assign o_s_axi_wready  = ~st.w_got_reg & ~st.bvalid_reg;
  assign o_s_axi_bvalid  = st.bvalid_reg;
  assign o_s_axi_bresp   = st.bresp_reg;
  assign o_s_axi_arready = ~st.rvalid_reg;
  assign o_s_axi_rvalid  = st.rvalid_reg;
  assign o_s_axi_rdata   = st.rdata_reg;
  assign o_s_axi_rresp   = st.rresp_reg;

endmodule : ldi_core

// [testbench/ldi_core_asserts.sv]
/*
  Pin-level assertions for ldi_core, bound to every instance.
  Assumes pins are held for several clocks, as the link contract asks.
*/
`timescale 1ns/1ns
`include "ldi_regs.svh"

module ldi_core_asserts (
  input wire logic                      i_clk_sys,
  input wire logic                      i_sys_rst,
  input wire logic                      i_driver_role_sel,
  input wire logic                      i_shift_direction_sel,
  input wire logic                      i_chain_enable_left_n,
  input wire logic                      i_frame_invert,
  input wire logic                      i_display_off_n,
  input wire logic                      i_latch_clock,
  input wire logic                      o_chain_enable_left_n,
  input wire logic                      o_chain_enable_left_oe,
  input wire logic                      o_chain_enable_right_n,
  input wire logic                      o_chain_enable_right_oe,
  input wire logic                      o_data_pin_two_left_end_oe,
  input wire logic                      o_data_pin_four_right_end_oe,
  input wire logic [2*`LDI_NUM_OUT-1:0] o_drive_outputs
);
  logic       any_um;
  logic       any_lm;
  logic [3:0] off_cnt;

  always_comb begin
    any_um = 1'b0;
    any_lm = 1'b0;
    for (int i = 0; i < `LDI_NUM_OUT; i++) begin
      any_um = any_um | (o_drive_outputs[2*i+:2] == 2'h1);
      any_lm = any_lm | (o_drive_outputs[2*i+:2] == 2'h2);
    end
  end

  // Saturating count of cycles with display off
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_display_off_n) off_cnt <= 4'h0;
    else if (off_cnt != 4'hF) off_cnt <= off_cnt + 4'h1;
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  property p_off; off_cnt > 4'h6 |-> o_drive_outputs == '0; endproperty
  a_off: assert property (p_off) else $error("outputs not at top level");
  property p_com_en; i_driver_role_sel [*5] |-> !o_chain_enable_left_oe && !o_chain_enable_right_oe; endproperty
  a_com_en: assert property (p_com_en) else $error("enable pin driven in common");
  property p_com_lr; (i_driver_role_sel && !i_shift_direction_sel) [*5]
    |-> o_data_pin_four_right_end_oe && !o_data_pin_two_left_end_oe; endproperty
  a_com_lr: assert property (p_com_lr) else $error("common pin direction wrong");
  property p_com_rl; (i_driver_role_sel && i_shift_direction_sel) [*5]
    |-> o_data_pin_two_left_end_oe && !o_data_pin_four_right_end_oe; endproperty
  a_com_rl: assert property (p_com_rl) else $error("common pin direction wrong");
  property p_seg_lr; (!i_driver_role_sel && !i_shift_direction_sel) [*5]
    |-> o_chain_enable_right_oe && !o_chain_enable_left_oe; endproperty
  a_seg_lr: assert property (p_seg_lr) else $error("enable out pin wrong");
  property p_seg_rl; (!i_driver_role_sel && i_shift_direction_sel) [*5]
    |-> o_chain_enable_left_oe && !o_chain_enable_right_oe; endproperty
  a_seg_rl: assert property (p_seg_rl) else $error("enable out pin wrong");
  property p_frame_lo; !i_frame_invert [*8] |-> !any_lm; endproperty
  a_frame_lo: assert property (p_frame_lo) else $error("level not allowed for frame low");
  property p_frame_hi; i_frame_invert [*8] |-> !any_um; endproperty
  a_frame_hi: assert property (p_frame_hi) else $error("level not allowed for frame high");
  property p_idle; (!i_driver_role_sel && !i_shift_direction_sel && i_chain_enable_left_n) [*8]
    |-> !$fell(o_chain_enable_right_n); endproperty
  a_idle: assert property (p_idle) else $error("filled while disabled");
  property p_latch_hi; (!i_driver_role_sel && i_latch_clock) [*6]
    |-> o_chain_enable_right_n && o_chain_enable_left_n; endproperty
  a_latch_hi: assert property (p_latch_hi) else $error("latch high left block full");
endmodule : ldi_core_asserts

bind ldi_core ldi_core_asserts u_asserts (.*);

// [testbench/ldi_ctl_model.sv]
/*
  Behavioural display controller: data pins, shift clock and latch clock.
  Assumes its tasks are called one at a time; clocks rest low between them.
*/
`timescale 1ns/1ns

module ldi_ctl_model (
  output logic [3:0] o_data,
  output logic       o_shift_clock,
  output logic       o_latch_clock
);
  initial begin
    o_data = 4'hF;
    o_shift_clock = 1'b0;
    o_latch_clock = 1'b0;
  end

  // One 125 ns shift-clock period; data held about 3 clocks past the fall
  task automatic put(input logic [3:0] d);
    o_data <= d;
    #32 o_shift_clock <= 1'b1;
    #62 o_shift_clock <= 1'b0;
    #31;
  endtask : put

  task automatic latch();
    #32 o_latch_clock <= 1'b1;
    #62 o_latch_clock <= 1'b0;
    #31;
  endtask : latch

  task automatic com(input logic [3:0] d);
    o_data <= d;
    latch();
  endtask : com

  // Released pins show the inverse, so stale data cannot pass by luck
  task automatic idle();
    o_data <= ~o_data;
  endtask : idle
endmodule : ldi_ctl_model

// [testbench/lcd_driver_data_interface_test.sv]
/*
  Self-checking bench for ldi_core: AXI4-Lite master, controller model,
  expectation queue drained by a watcher.
  Assumes ldi_regs.svh on the include path.
*/
`timescale 1ns/1ns
`include "ldi_regs.svh"
`define CHECK(nm, g) begin \
  ev = expq.pop_front(); \
  compares++; \
  if ((g) !== ev) begin \
    n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ev, g); \
  end end

module lcd_driver_data_interface_test;
  logic         clk, rst, role, application_mode_sel, dir, frm, don, en_l, en_r, shc, ltc;
  logic [3:0]   pd;
  logic         l_o, l_oe, r_o, r_oe, el_o, el_oe, er_o, er_oe;
  logic [159:0] drv, ev, obs;
  logic [7:0]   awa, ara;
  logic [31:0]  wd, rd;
  logic [1:0]   bresp, rresp;
  logic         awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [79:0]  ex;
  logic [159:0] expq[$];
  string        obs_nm;
  event         look_ev;
  int           n_mismatch, compares, cyc;
  // Two-way pins resolved from the enables
  wire          left_w = l_oe ? l_o : pd[1];
  wire          right_w = r_oe ? r_o : pd[3];
  wire          enl_w = el_oe ? el_o : en_l;
  wire          enr_w = er_oe ? er_o : en_r;

  ldi_core u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_data_pin_one_serial_in(pd[0]), .i_data_pin_two_left_end(left_w),
    .o_data_pin_two_left_end(l_o), .o_data_pin_two_left_end_oe(l_oe), .i_data_pin_three_middle(pd[2]),
    .i_data_pin_four_right_end(right_w), .o_data_pin_four_right_end(r_o), .o_data_pin_four_right_end_oe(r_oe),
    .i_shift_direction_sel(dir), .i_chain_enable_left_n(enl_w), .o_chain_enable_left_n(el_o),
    .o_chain_enable_left_oe(el_oe), .i_chain_enable_right_n(enr_w), .o_chain_enable_right_n(er_o),
    .o_chain_enable_right_oe(er_oe), .i_application_mode_sel(application_mode_sel), .i_driver_role_sel(role),
    .i_frame_invert(frm), .i_display_off_n(don), .i_latch_clock(ltc), .i_shift_clock(shc),
    .o_drive_outputs(drv), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rr));

  ldi_ctl_model u_ctl (.o_data(pd), .o_shift_clock(shc), .o_latch_clock(ltc));

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic look(input string nm, input logic [159:0] e, input logic [159:0] g);
    expq.push_back(e);
    obs_nm = nm;
    obs = g;
    -> look_ev;
    @(posedge clk);
  endtask : look

  task automatic setup(input logic [4:0] c);
    @(posedge clk);
    {role, application_mode_sel, dir, en_l, en_r} <= c;
    repeat (8) @(posedge clk);
  endtask : setup

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge clk);
    expq.push_back(160'(resp));
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!(bv && br));
    br <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge clk);
    expq.push_back(160'({resp, d}));
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!(rv && rr));
    rr <= 1'b0;
  endtask : axi_rd

  task automatic chk_data(input logic [79:0] v);
    axi_rd(`LDI_OFF_DATA0, v[31:0], `LDI_RESP_OKAY);
    axi_rd(`LDI_OFF_DATA1, v[63:32], `LDI_RESP_OKAY);
    axi_rd(`LDI_OFF_DATA2, {16'h0, v[79:64]}, `LDI_RESP_OKAY);
  endtask : chk_data

  // Both frame phases: 0 top, 1 upper mid, 2 lower mid, 3 bottom
  task automatic chk_drv(input logic [79:0] b, input logic com, input logic on);
    logic [159:0] e;
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      frm <= f[0];
      repeat (12) @(posedge clk);
      for (int i = 0; i < 80; i++)
        e[2*i+:2] = !on ? 2'h0 : f[0] ? (b[i] ? (com ? 2'h0 : 2'h3) : 2'h2) : (b[i] ? (com ? 2'h3 : 2'h0) : 2'h1);
      look("drive", e, drv);
    end
  endtask : chk_drv

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      complete_run();
    end
    if (bv && br) `CHECK("write response", 160'(bresp))
    if (rv && rr) `CHECK("read", 160'({rresp, rd}))
  end

  always @(look_ev) `CHECK(obs_nm, obs)

  initial begin
    logic [3:0] w;
    logic       b;
    logic       m;
    {rst, role, application_mode_sel, dir, frm, en_l, en_r, don} = 8'h81;
    {awv, wv, br, arv, rr} = 5'h0;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(94290));
    repeat (4) @(posedge clk);
    axi_rd(`LDI_OFF_CTRL, 32'h0, `LDI_RESP_OKAY);
    axi_rd(`LDI_OFF_STATUS, 32'h8, `LDI_RESP_OKAY);
    axi_rd(8'hFC, 32'h0, `LDI_RESP_SLVERR);
    axi_wr(8'hFC, 32'h1, `LDI_RESP_SLVERR);
    // Parallel, left to right, one word past full
    setup(5'b00001);
    u_ctl.latch();
    ex = '0;
    for (int k = 0; k < 21; k++) begin
      w = 4'($urandom);
      u_ctl.put(w);
      if (k < 20) ex = {ex[75:0], w};
    end
    u_ctl.idle();
    setup(5'b00001);
    look("enable out", 160'(2'b10), 160'({er_oe, er_o}));
    axi_rd(`LDI_OFF_STATUS, 32'h1418, `LDI_RESP_OKAY);
    u_ctl.latch();
    chk_data(ex);
    look("enable out", 160'(2'b11), 160'({er_oe, er_o}));
    chk_drv(ex, 1'b0, 1'b1);
    @(posedge clk);
    don <= 1'b0;
    chk_drv(ex, 1'b0, 1'b0);
    don <= 1'b1;
    // Serial, right to left, noise on the unused pins
    setup(5'b01110);
    u_ctl.latch();
    for (int k = 0; k < 80; k++) begin
      b = 1'($urandom);
      u_ctl.put({3'($urandom), b});
      ex = {b, ex[79:1]};
    end
    u_ctl.idle();
    setup(5'b01110);
    look("enable out", 160'(2'b10), 160'({el_oe, el_o}));
    u_ctl.latch();
    chk_data(ex);
    // Disabled: shift clocks ignored
    setup(5'b00010);
    u_ctl.latch();
    for (int k = 0; k < 4; k++) u_ctl.put(4'($urandom));
    u_ctl.idle();
    axi_rd(`LDI_OFF_STATUS, 32'h0, `LDI_RESP_OKAY);
    u_ctl.latch();
    chk_data(ex);
    // Parallel, right to left, first pin lands on the top bit
    setup(5'b00100);
    u_ctl.latch();
    for (int k = 0; k < 3; k++) begin
      w = 4'($urandom);
      u_ctl.put(w);
      ex = {w[0], w[1], w[2], w[3], ex[79:4]};
    end
    u_ctl.latch();
    chk_data(ex);
    // Common single, left to right; shift clock must not move data
    setup(5'b10000);
    for (int k = 0; k < 80; k++) begin
      b = 1'($urandom);
      u_ctl.com({2'b11, b, 1'b1});
      ex = {ex[78:0], b};
    end
    u_ctl.put(4'h0);
    u_ctl.idle();
    setup(5'b10000);
    chk_data(ex);
    look("end pins", 160'({2'b01, ex[79]}), 160'({l_oe, r_oe, r_o}));
    look("enable oe", 160'(2'b00), 160'({el_oe, er_oe}));
    chk_drv(ex, 1'b1, 1'b1);
    // Common dual, right to left, middle feeds lower half
    setup(5'b11100);
    for (int k = 0; k < 40; k++) begin
      b = 1'($urandom);
      m = 1'($urandom);
      u_ctl.com({b, m, 2'b11});
      ex = {b, ex[79:41], m, ex[39:1]};
    end
    u_ctl.idle();
    setup(5'b11100);
    chk_data(ex);
    look("end pins", 160'({2'b10, ex[0]}), 160'({l_oe, r_oe, l_o}));
    axi_wr(`LDI_OFF_CTRL, 32'h1, `LDI_RESP_OKAY);
    axi_rd(`LDI_OFF_CTRL, 32'h1, `LDI_RESP_OKAY);
    chk_drv(ex, 1'b1, 1'b0);
    axi_wr(`LDI_OFF_CTRL, 32'h0, `LDI_RESP_OKAY);
    complete_run();
  end
endmodule : lcd_driver_data_interface_test
